// file: hw/line_printer_adapter.sv
// Line printer adapter between the I/O micro-bus and a parallel line printer.
`timescale 1ns/10ps
`default_nettype none
module line_printer_adapter
    import line_printer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic colSelect,
    input wire logic [ROW_W-1:0] rowAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [0:BUS_W-1] busIn,
    output logic [0:BUS_W-1] busOut,
    output logic busDriveN,
    output logic serviceRequest,
    input wire logic demand,
    input wire printer_status_t printerStatus,
    output logic [0:7] printerDataLines,
    output logic dataStrobe,
    output logic formatControl
);

    // Legal read rows are the first four.
    function automatic logic readRowLegal(input logic [ROW_W-1:0] row);
        readRowLegal = (row <= RD_LAST_LEGAL);
    endfunction : readRowLegal

    // Register contents.
    logic [0:7] commandByte_q;
    logic [0:7] printCharacter_q;
    // Flags of the adapter.
    logic processorRequest_q;
    logic strobe_q;
    logic demandLatch_q;
    logic formatPending_q;
    logic readyLatch_q;
    logic attention_q;
    logic deviceEnd_q;
    logic active_q;
    logic reject_q;
    logic busyPrev_q;
    // Delayed synchronised demand for edge detection.
    logic demandPrev_q;
    // Synchronised printer inputs.
    logic demandSync;
    printer_status_t statusSync;
    // Results of the command checker.
    logic invalidCmd;
    logic [0:7] formatCode;
    // Decoded bus cycles.
    logic wrCycle;
    logic rdCycle;
    logic doLoadPrint;
    logic doLoadCmd;
    logic doStart;
    logic doHalt;
    logic doClear;
    logic doResetDev;
    logic doExecFormat;
    logic illegalAccess;
    // Derived conditions.
    logic demandRise;
    logic readyNow;
    logic busyNow;
    logic printAccepted;
    logic formatAccepted;
    logic strobeDone;
    logic formatDone;
    logic [0:BUS_W-1] readWord;
    status_word_t statusWord;
    sense_word_t senseWord;

    // Synchronise the demand line before it is used.
    bit_sync #(
        .WIDTH(1)
    ) u_demand_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .clkEn(clkEn),
        .asyncIn(demand),
        .syncOut(demandSync)
    );

    // Synchronise the printer status lines as well.
    bit_sync #(
        .WIDTH($bits(printer_status_t))
    ) u_status_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .clkEn(clkEn),
        .asyncIn(printerStatus),
        .syncOut(statusSync)
    );

    // Invalid command detection and format code correction.
    command_check u_command_check (
        .commandByte(commandByte_q),
        .invalidCmd(invalidCmd),
        .formatCode(formatCode)
    );

    // Decode the write row into load and control functions.
    always_comb
    begin
        wrCycle = ioWrite && colSelect;
        rdCycle = ioRead && colSelect;
        doLoadPrint = wrCycle && (rowAddr == WR_LOAD_PRINT);
        doLoadCmd = wrCycle && (rowAddr == WR_LOAD_CMD);
        doStart = wrCycle && (rowAddr == WR_START);
        doHalt = wrCycle && (rowAddr == WR_HALT);
        doClear = wrCycle && (rowAddr == WR_CLEAR_STATUS);
        doResetDev = wrCycle && (rowAddr == WR_RESET_DEVICE);
        doExecFormat = wrCycle && (rowAddr == WR_EXEC_FORMAT);
        illegalAccess = (wrCycle && (rowAddr == WR_ILLEGAL)) || (rdCycle && !readRowLegal(rowAddr));
    end

    // Derived handshake and status conditions.
    always_comb
    begin
        demandRise = demandSync && !demandPrev_q;
        readyNow = statusSync.ready && statusSync.online && !statusSync.formsJam
                   && !statusSync.endOfForms && !statusSync.tapeMissing;
        busyNow = demandLatch_q || formatPending_q;
        // A print load is only sent when the device is free, ready and active.
        printAccepted = doLoadPrint && !busyNow && readyLatch_q && active_q;
        // A format request is only sent for a valid command while active.
        formatAccepted = doExecFormat && !invalidCmd && active_q && !formatPending_q;
        // The printer dropping demand means it took the character.
        strobeDone = strobe_q && !demandSync;
        // Demand coming back completes the outstanding character.
        formatDone = formatPending_q && demandLatch_q && demandRise;
    end

    // Command register, loaded from bus bits 8 to 15.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            commandByte_q <= CMD_RESET;
        end
        else if (clkEn && doLoadCmd)
        begin
            commandByte_q <= busIn[BYTE_HI:BYTE_LO];
        end
    end

    // Print data register; processor loads are always stored for diagnostics.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            printCharacter_q <= PRINT_RESET;
        end
        else if (clkEn && doLoadPrint)
        begin
            printCharacter_q <= busIn[BYTE_HI:BYTE_LO];
        end
    end

    // Printer data lines carry the print register or the corrected format code.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            printerDataLines <= PRINT_RESET;
        end
        else if (clkEn)
        begin
            if (formatPending_q)
            begin
                printerDataLines <= formatCode;
            end
            else
            begin
                printerDataLines <= printCharacter_q;
            end
        end
    end

    // Processor request flag; a new demand wins over a clear in the same cycle.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            processorRequest_q <= 1'b0;
        end
        else if (clkEn)
        begin
            // The demand that ends a format character also asks for the next line's data.
            if (demandRise && active_q && !reject_q)
            begin
                processorRequest_q <= 1'b1;
            end
            else if (doLoadPrint || doExecFormat || doResetDev || doHalt)
            begin
                processorRequest_q <= 1'b0;
            end
        end
    end

    // Data strobe latch; set by an accepted character, dropped when the printer takes it.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            strobe_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (printAccepted || formatAccepted)
            begin
                strobe_q <= 1'b1;
            end
            else if (strobeDone || doResetDev || doHalt)
            begin
                strobe_q <= 1'b0;
            end
        end
    end

    // Demand latch marks a character outstanding until demand returns.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            demandLatch_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (printAccepted || formatAccepted)
            begin
                demandLatch_q <= 1'b1;
            end
            else if ((demandRise && !strobe_q) || doResetDev || doHalt)
            begin
                demandLatch_q <= 1'b0;
            end
        end
    end

    // Format pending flag, raised by execute format and ended by its handshake.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            formatPending_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (formatAccepted)
            begin
                formatPending_q <= 1'b1;
            end
            else if ((formatDone && !strobe_q) || doResetDev || doHalt)
            begin
                formatPending_q <= 1'b0;
            end
        end
    end

    // Ready latch and delayed busy for edge detection.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            readyLatch_q <= 1'b0;
            busyPrev_q <= 1'b0;
            demandPrev_q <= 1'b0;
        end
        else if (clkEn)
        begin
            readyLatch_q <= readyNow;
            busyPrev_q <= busyNow;
            demandPrev_q <= demandSync;
        end
    end

    // Attention flag; a ready rise wins over clear status.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            attention_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (readyNow && !readyLatch_q)
            begin
                attention_q <= 1'b1;
            end
            else if (doClear || doResetDev)
            begin
                attention_q <= 1'b0;
            end
        end
    end

    // Device end flag; set when busy ends or the printer becomes ready.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            deviceEnd_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if ((busyPrev_q && !busyNow) || (readyNow && !readyLatch_q))
            begin
                deviceEnd_q <= 1'b1;
            end
            else if (doClear || doResetDev)
            begin
                deviceEnd_q <= 1'b0;
            end
        end
    end

    // Active flag; start needs a ready printer, halt and device reset end it.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            active_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (doStart && readyLatch_q)
            begin
                active_q <= 1'b1;
            end
            else if (doHalt || doResetDev)
            begin
                active_q <= 1'b0;
            end
        end
    end

    // Command reject flag; any reject cause wins over clear status.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            reject_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (illegalAccess || (doExecFormat && invalidCmd)
                || (doLoadPrint && (busyNow || !readyLatch_q)))
            begin
                reject_q <= 1'b1;
            end
            else if (doClear || doResetDev)
            begin
                reject_q <= 1'b0;
            end
        end
    end

    // Assemble status, sense and the selected read word.
    always_comb
    begin
        statusWord.attention = attention_q;
        statusWord.busy = busyNow;
        statusWord.deviceEnd = deviceEnd_q;
        statusWord.unitCheck = reject_q;
        statusWord.requestIn = serviceRequest;
        senseWord.commandReject = reject_q;
        senseWord.intervention = !readyLatch_q;
        senseWord.dataCheck = 1'b0;
        senseWord.notReady = !readyLatch_q;
        senseWord.online = statusSync.online;
        senseWord.formsJam = statusSync.formsJam;
        senseWord.endOfForms = statusSync.endOfForms;
        senseWord.tapeMissing = statusSync.tapeMissing;
        senseWord.formatPending = formatPending_q;
        senseWord.demand = demandSync;
        senseWord.dataRequest = processorRequest_q;
        readWord = BUS_RESET;
        case (rowAddr)
            RD_PRINTER_DATA: readWord[BYTE_HI:BYTE_LO] = printerDataLines;
            RD_COMMAND: readWord[BYTE_HI:BYTE_LO] = commandByte_q;
            RD_STATUS: readWord = {11'h000, statusWord};
            RD_SENSE: readWord = {5'h00, senseWord};
            default: readWord = BUS_RESET;
        endcase
    end

    // Bus drivers are enabled for one cycle after a legal read.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busOut <= BUS_RESET;
            busDriveN <= 1'b1;
        end
        else if (clkEn)
        begin
            busOut <= rdCycle ? readWord : BUS_RESET;
            busDriveN <= !(rdCycle && readRowLegal(rowAddr));
        end
    end

    // Printer control outputs and the service request line.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dataStrobe <= 1'b0;
            formatControl <= 1'b0;
            serviceRequest <= 1'b0;
        end
        else if (clkEn)
        begin
            dataStrobe <= strobe_q;
            formatControl <= formatPending_q;
            serviceRequest <= attention_q || (active_q && (processorRequest_q || deviceEnd_q
                              || reject_q || !readyLatch_q));
        end
    end

endmodule : line_printer_adapter
`default_nettype wire

// file: hw/line_printer_pkg.sv
// Package with the constants, field layouts and carrier types of the line printer adapter.
package line_printer_pkg;

    // Width of the micro-bus; bits are numbered 0 (most significant) to 15.
    localparam int BUS_W = 16;
    // Byte lane used by byte-wide registers on the micro-bus.
    localparam int BYTE_HI = 8;
    localparam int BYTE_LO = 15;
    // Width of the row address.
    localparam int ROW_W = 3;

    // Write row addresses.
    localparam logic [2:0] WR_LOAD_PRINT = 3'h0;
    localparam logic [2:0] WR_LOAD_CMD = 3'h1;
    localparam logic [2:0] WR_START = 3'h2;
    localparam logic [2:0] WR_HALT = 3'h3;
    localparam logic [2:0] WR_CLEAR_STATUS = 3'h4;
    localparam logic [2:0] WR_RESET_DEVICE = 3'h5;
    localparam logic [2:0] WR_EXEC_FORMAT = 3'h6;
    localparam logic [2:0] WR_ILLEGAL = 3'h7;

    // Read row addresses; rows 4 to 7 are unused and illegal.
    localparam logic [2:0] RD_PRINTER_DATA = 3'h0;
    localparam logic [2:0] RD_COMMAND = 3'h1;
    localparam logic [2:0] RD_STATUS = 3'h2;
    localparam logic [2:0] RD_SENSE = 3'h3;
    localparam logic [2:0] RD_LAST_LEGAL = 3'h3;

    // Vertical format field inside the command byte (bit 0 is the most significant).
    localparam int FMT_HI = 0;
    localparam int FMT_LO = 3;
    localparam int FMT_W = 4;
    // Low four command bits examined for invalid commands.
    localparam logic [3:0] CMD_INVALID_A = 4'h0;
    localparam logic [3:0] CMD_INVALID_B = 4'h8;
    localparam logic [3:0] CMD_INVALID_C = 4'hC;

    // Reset values.
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] PRINT_RESET = 8'h00;
    localparam logic [15:0] BUS_RESET = 16'h0000;

    // Number of flip-flops in the input synchroniser.
    localparam int SYNC_STAGES = 2;

    // Status lines that the printer reports.
    typedef struct packed {
        logic ready;
        logic online;
        logic formsJam;
        logic endOfForms;
        logic tapeMissing;
    } printer_status_t;

    // Status word, read at bus bits 11 to 15.
    typedef struct packed {
        logic attention;
        logic busy;
        logic deviceEnd;
        logic unitCheck;
        logic requestIn;
    } status_word_t;

    // Sense word, read at bus bits 5 to 15.
    typedef struct packed {
        logic commandReject;
        logic intervention;
        logic dataCheck;
        logic notReady;
        logic online;
        logic formsJam;
        logic endOfForms;
        logic tapeMissing;
        logic formatPending;
        logic demand;
        logic dataRequest;
    } sense_word_t;

endpackage : line_printer_pkg

// file: hw/bit_sync.sv
// Two-stage synchroniser for a group of slow input levels.
`timescale 1ns/10ps
`default_nettype none
module bit_sync
    import line_printer_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // First stage; it feeds only the second stage.
    logic [WIDTH-1:0] stage1_q;

    // One synchroniser chain for each input bit.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    stage1_q[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end
                else if (clkEn)
                begin
                    stage1_q[i] <= asyncIn[i];
                    syncOut[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

endmodule : bit_sync
`default_nettype wire

// file: hw/command_check.sv
// Invalid command detection and vertical format code correction.
`timescale 1ns/10ps
`default_nettype none
module command_check
    import line_printer_pkg::*;
(
    input wire logic [0:7] commandByte,
    output logic invalidCmd,
    output logic [0:7] formatCode
);

    // Field values taken from the command byte.
    logic [3:0] lowBits;
    logic [FMT_W-1:0] fmtField;
    logic [FMT_W-1:0] fmtCorrected;

    // Flag the three invalid patterns of the low four bits.
    always_comb
    begin
        lowBits = commandByte[4:7];
        invalidCmd = (lowBits == CMD_INVALID_A) || (lowBits == CMD_INVALID_B)
                     || (lowBits == CMD_INVALID_C);
    end

    // The printer expects codes one lower than software uses, so subtract one.
    always_comb
    begin
        fmtField = commandByte[FMT_HI:FMT_LO];
        fmtCorrected = fmtField - {{(FMT_W-1){1'b0}}, 1'b1};
        formatCode = {{(8-FMT_W){1'b0}}, fmtCorrected};
    end

endmodule : command_check
`default_nettype wire

// file: sim/printer_model.sv
// Behavioural printer model for the character handshake.
`timescale 1ns/10ps
`default_nettype none
module printer_model
(
    input wire logic ref_clk,
    input wire logic feed,
    input wire logic slow,
    input wire logic dataStrobe,
    input wire logic [0:7] printerDataLines,
    input wire logic formatControl,
    output logic demand,
    output logic [0:7] lastChar,
    output logic lastFmt
);
    // Cycles waited since the strobe dropped.
    int waitCnt = 0;
    initial
    begin
        demand = 1'b0;
        lastChar = 8'h00;
        lastFmt = 1'b0;
    end
    // Takes a strobed character, drops demand, then asks again after a short or long pause.
    always @(posedge ref_clk)
    begin
        if (demand && dataStrobe)
        begin
            demand <= 1'b0;
            lastChar <= printerDataLines;
            lastFmt <= formatControl;
            waitCnt <= 0;
        end
        else if (feed && !demand && !dataStrobe)
        begin
            waitCnt <= waitCnt + 1;
            if (waitCnt >= (slow ? 20 : 1))
            begin
                demand <= 1'b1;
                waitCnt <= 0;
            end
        end
    end
endmodule : printer_model
`default_nettype wire

// file: sim/line_printer_adapter_sva.sv
// Port checker for the line printer adapter.
`timescale 1ns/10ps
`default_nettype none
module line_printer_adapter_sva
    import line_printer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic colSelect,
    input wire logic [ROW_W-1:0] rowAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [0:BUS_W-1] busIn,
    input wire logic [0:BUS_W-1] busOut,
    input wire logic busDriveN,
    input wire logic serviceRequest,
    input wire logic demand,
    input wire logic [0:7] printerDataLines,
    input wire logic dataStrobe,
    input wire logic formatControl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Accesses taken at this edge.
    wire logic wrTake = clkEn && colSelect && ioWrite;
    wire logic rdTake = clkEn && colSelect && ioRead;
    // Shadow copy of the command byte.
    logic [0:7] cmdShadow_q;
    wire logic cmdBad = cmdShadow_q[4:7] inside {CMD_INVALID_A, CMD_INVALID_B, CMD_INVALID_C};
    // Follows command loads so the format code can be predicted.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cmdShadow_q <= CMD_RESET;
        end
        else if (wrTake && rowAddr == WR_LOAD_CMD)
        begin
            cmdShadow_q <= busIn[BYTE_HI:BYTE_LO];
        end
    end
    a_read_drive: assert property (rdTake && rowAddr <= RD_LAST_LEGAL |=> !busDriveN)
        else $error("legal read did not drive the bus");
    a_bus_quiet: assert property (clkEn && !(colSelect && ioRead && rowAddr <= RD_LAST_LEGAL)
        |=> busDriveN && busOut == BUS_RESET) else $error("bus driven without a legal read");
    a_print_load: assert property (wrTake && rowAddr == WR_LOAD_PRINT ##2 !formatControl
        |-> printerDataLines == $past(busIn[BYTE_HI:BYTE_LO], 2)) else $error("print character not on data lines");
    a_format_code: assert property (formatControl |-> printerDataLines == {4'h0, cmdShadow_q[FMT_HI:FMT_LO] - 4'h1})
        else $error("format code not corrected");
    a_invalid_format: assert property (wrTake && rowAddr == WR_EXEC_FORMAT && cmdBad && !formatControl
        |=> !formatControl [*2]) else $error("invalid command started a format");
    a_format_strobe: assert property ($rose(formatControl) |-> ##[0:2] dataStrobe)
        else $error("format character not strobed");
    a_strobe_drop: assert property (dataStrobe && $fell(demand) |-> ##[1:5] !dataStrobe)
        else $error("strobe stayed after demand fell");
    a_strobe_hold: assert property (dataStrobe && demand && !wrTake && !$past(wrTake) |=> dataStrobe)
        else $error("strobe dropped while demand high");
    a_reset_state: assert property (disable iff (1'b0) srst |=> busDriveN && !dataStrobe && !formatControl
        && !serviceRequest && busOut == BUS_RESET && printerDataLines == PRINT_RESET) else $error("bad reset state");
    c_status_read: cover property (rdTake && rowAddr == RD_STATUS);
    c_format: cover property ($rose(formatControl));
    c_strobe: cover property ($rose(dataStrobe));
    c_request: cover property ($rose(serviceRequest));
endmodule : line_printer_adapter_sva
bind line_printer_adapter line_printer_adapter_sva chk (.ref_clk, .srst, .clkEn, .colSelect, .rowAddr, .ioWrite,
    .ioRead, .busIn, .busOut, .busDriveN, .serviceRequest, .demand, .printerDataLines, .dataStrobe, .formatControl);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the line printer adapter.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin numErrors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WAITU(c) for (int k = 0; k < 300 && !(c); k++) @(negedge ref_clk);
module tb
    import line_printer_pkg::*;
;
    typedef struct packed {logic [7:0] cmd; logic [7:0] chr; logic rej;} row_t;
    // Command, character and expected reject per ordinary case.
    row_t rows [6] = '{'{8'h10, 8'h5A, 1'b1}, '{8'h18, 8'hA5, 1'b1}, '{8'h1C, 8'h0F, 1'b1},
        '{8'h21, 8'hF0, 1'b0}, '{8'h3F, 8'h81, 1'b0}, '{8'h04, 8'h7E, 1'b0}};
    logic ref_clk = 1'b0, srst = 1'b1, colSelect = 1'b0, ioWrite = 1'b0, ioRead = 1'b0, feed = 1'b0, slow = 1'b0;
    logic clkEn = 1'b1;
    logic [2:0] rowAddr = 3'h0;
    logic [0:15] busIn = 16'h0000, busOut, rd;
    logic busDriveN, serviceRequest, demand, dataStrobe, formatControl, lastFmt;
    logic [0:7] printerDataLines, lastChar;
    printer_status_t pStat = 5'h18;
    int numErrors = 0, testsRun = 0, cycles = 0;
    line_printer_adapter DUT (.ref_clk, .srst, .clkEn, .colSelect, .rowAddr, .ioWrite, .ioRead, .busIn,
        .busOut, .busDriveN, .serviceRequest, .demand, .printerStatus(pStat), .printerDataLines, .dataStrobe,
        .formatControl);
    printer_model prn (.ref_clk, .feed, .slow, .dataStrobe, .printerDataLines, .formatControl, .demand,
        .lastChar, .lastFmt);
    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Prints the counts and the verdict, then stops.
    task testDone;
        $display("Checks %0d, errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : testDone
    // Cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            numErrors++;
            testDone();
        end
    end
    // One write pulse carrying a byte on bits 8 to 15.
    task wr(input logic [2:0] r, input logic [0:7] d);
        @(negedge ref_clk);
        colSelect = 1'b1;
        rowAddr = r;
        busIn = {8'h00, d};
        ioWrite = 1'b1;
        @(negedge ref_clk);
        ioWrite = 1'b0;
    endtask : wr
    // One read pulse; the answer stands in the following cycle.
    task rdr(input logic [2:0] r);
        @(negedge ref_clk);
        colSelect = 1'b1;
        rowAddr = r;
        ioRead = 1'b1;
        @(negedge ref_clk);
        ioRead = 1'b0;
        rd = busOut;
    endtask : rdr
    initial
    begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        repeat (6) @(negedge ref_clk);
        rdr(RD_STATUS);
        `CHK("drive", 1'b0, busDriveN)
        `CHK("attention", 1'b1, rd[11])
        `CHK("devEnd", 1'b1, rd[13])
        wr(WR_CLEAR_STATUS, 8'h00);
        rdr(RD_STATUS);
        `CHK("attnClr", 1'b0, rd[11])
        // A write while the clock enable is low must not land.
        clkEn = 1'b0;
        wr(WR_LOAD_CMD, 8'hAA);
        clkEn = 1'b1;
        rdr(RD_COMMAND);
        `CHK("freeze", 8'h00, rd[8:15])
        // Ordinary cases while not active: no transfer, reject only on invalid commands.
        foreach (rows[i])
        begin
            wr(WR_LOAD_CMD, rows[i].cmd);
            wr(WR_LOAD_PRINT, rows[i].chr);
            wr(WR_EXEC_FORMAT, 8'h00);
            rdr(RD_COMMAND);
            `CHK("cmd", rows[i].cmd, rd[8:15])
            rdr(RD_PRINTER_DATA);
            `CHK("data", rows[i].chr, rd[8:15])
            rdr(RD_STATUS);
            `CHK("reject", rows[i].rej, rd[14])
            `CHK("idleStrobe", 1'b0, dataStrobe)
            wr(WR_CLEAR_STATUS, 8'h00);
        end
        wr(WR_ILLEGAL, 8'h00);
        rdr(3'h5);
        `CHK("noDrive", 1'b1, busDriveN)
        rdr(RD_SENSE);
        `CHK("badRow", 1'b1, rd[5])
        wr(WR_CLEAR_STATUS, 8'h00);
        // Character transfer with a refused load while busy.
        wr(WR_START, 8'h00);
        feed = 1'b1;
        `WAITU(serviceRequest === 1'b1)
        `CHK("srq", 1'b1, serviceRequest)
        rdr(RD_SENSE);
        `CHK("procReq", 1'b1, rd[15])
        wr(WR_LOAD_PRINT, 8'hC3);
        `WAITU(dataStrobe === 1'b1)
        `CHK("lines", 8'hC3, printerDataLines)
        rdr(RD_STATUS);
        `CHK("busy", 1'b1, rd[12])
        wr(WR_LOAD_PRINT, 8'h3C);
        rdr(RD_SENSE);
        `CHK("busyLoad", 1'b1, rd[5])
        `CHK("taken", 8'hC3, lastChar)
        wr(WR_CLEAR_STATUS, 8'h00);
        `WAITU(demand === 1'b1 && dataStrobe === 1'b0)
        repeat (4) @(negedge ref_clk);
        rdr(RD_STATUS);
        `CHK("idle", 1'b0, rd[12])
        `CHK("done", 1'b1, rd[13])
        // An invalid command while active is rejected and starts no format.
        wr(WR_LOAD_CMD, 8'h38);
        wr(WR_EXEC_FORMAT, 8'h00);
        rdr(RD_STATUS);
        `CHK("actReject", 1'b1, rd[14])
        `CHK("noFormat", 1'b0, formatControl)
        wr(WR_CLEAR_STATUS, 8'h00);
        // Format character with a slow printer.
        wr(WR_LOAD_CMD, 8'h31);
        slow = 1'b1;
        wr(WR_EXEC_FORMAT, 8'h00);
        `WAITU(formatControl === 1'b1)
        `CHK("fmtCode", 8'h02, printerDataLines)
        `WAITU(formatControl === 1'b0)
        `CHK("fmtTaken", 8'h02, lastChar)
        `CHK("fmtFlag", 1'b1, lastFmt)
        `CHK("muxBack", 8'h3C, printerDataLines)
        // Loss of ready through a forms jam.
        pStat.formsJam = 1'b1;
        repeat (5) @(negedge ref_clk);
        rdr(RD_SENSE);
        `CHK("notReady", 1'b1, rd[8])
        `CHK("fmtReq", 1'b1, rd[15])
        wr(WR_HALT, 8'h00);
        `CHK("halted", 1'b0, dataStrobe)
        testDone();
    end
endmodule : tb
`default_nettype wire
